// [src/bfl_loader.sv]
/*
  Boot sequencer and serial flash image loader.
  Assumes asynchronous pin inputs, a mode 0 flash holding two headers,
  and an on-chip OTP address source on the system clock.
*/
`timescale 1ns/1ps
// Contract
// - Hold internal reset while regulator rail invalid; release starts boot.
// - Boot: reset registers, load trims, wait settle, then set addresses.
// - Unique address from OTP, debug control pins and address strap.
// - Dead battery: main invalid, adapter valid; then sample adapter select pin.
// - Enable 48 MHz clock; wait for supply persistence counters to confirm.
// - Finally enable thermal, converter, checksum, GPIO and interrupt blocks.
// - Bus addresses come from pin states read during boot; address A is taken from otp_addr_in instead when otp_addr_valid_in is set.
// - After both addresses exist, enable restricted host interface.
// - Read headers at byte 0x000000 and 0x001000, each 4 kB.
// - Each header gives a region pointer and an image offset.
// - Image start is region pointer plus image offset.
// - Leading image bytes are configuration settings.
// - Try low region first; on any invalid data switch to high.
// - Other region's validated image stays usable after failed update.
// - Both regions invalid enters invalid memory flow.
// - Invalid memory flow routes debug port to sideband pins.
// - 48 MHz clocks core and USB PHY; slow clock in low power.
// - Flash link is mode 0, select active low, clock idles low.
module bfl_loader
  import bfl_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              internal_regulator_rail_ok_in,
  input  wire logic              main_supply_input_ok_in,
  input  wire logic              adapter_supply_input_ok_in,
  input  wire logic              adapter_power_select_pin_in,
  input  wire logic [1:0]        debug_control_pins_in,
  input  wire logic [2:0]        addr_strap_in,
  input  wire logic              otp_addr_valid_in,
  input  wire logic [6:0]        otp_addr_in,
  input  wire logic              low_power_req_in,
  input  wire logic [CFG_AW-1:0] cfg_rd_addr_in,
  input  wire logic              flash_miso_in,
  output logic                   flash_sclk_out,
  output logic                   flash_mosi_out,
  output logic                   flash_select_n_out,
  output logic                   core_rst_n_out,
  output logic                   trim_load_out,
  output logic                   osc48_en_out,
  output logic                   core_slow_clk_out,
  output logic                   usb_phy_clk_en_out,
  output logic                   adapter_switch_en_out,
  output bfl_periph_s            periph_en_out,
  output logic [6:0]             bus_addr_a_out,
  output logic [6:0]             bus_addr_b_out,
  output logic                   host_if_en_out,
  output logic                   swd_route_out,
  output bfl_boot_e              boot_status_out,
  output logic                   cfg_valid_out,
  output logic [7:0]             cfg_rd_data_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  bfl_pins_s  pin_raw;
  bfl_pins_s  pin1_q;
  bfl_pins_s  pin_q;
  bfl_state_e state_q;
  logic [11:0] wait_q;
  logic [10:0] pcnt_q [2];
  logic [1:0]  pers_full;
  logic [1:0]  sup_ok;
  logic        deadbat_q;
  logic        busy_q;
  logic        done_q;
  logic        sclk_q;
  logic [2:0]  div_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_q;
  logic [7:0]  rx_q;
  logic        cs_n_q;
  logic        spi_go;
  logic [7:0]  spi_tx;
  logic        xfer_st;
  logic        xfer_last;
  logic [4:0]  idx_q;
  logic [23:0] addr_q;
  logic [63:0] hdr_q;
  logic [7:0]  sum_q;
  logic        hdr_mode_q;
  logic        high_q;
  logic        hdr_ok;
  logic [23:0] img_addr;
  logic [6:0]  addr_a_c;
  logic        lp_q;

  assign pin_raw = '{rail_ok: internal_regulator_rail_ok_in, main_ok: main_supply_input_ok_in,
                     adp_ok: adapter_supply_input_ok_in, adp_sel: adapter_power_select_pin_in,
                     debug_ctl: debug_control_pins_in, strap: addr_strap_in, miso: flash_miso_in};

  // Two stages; only the second stage feeds logic
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin1_q <= '0;
      pin_q  <= '0;
    end
    else
    begin
      pin1_q <= pin_raw;
      pin_q  <= pin1_q;
    end
  end

  // ----------------------------------------------------------------
  // Supply persistence counters
  // ----------------------------------------------------------------
  assign sup_ok = {pin_q.adp_ok, pin_q.main_ok};

  // Counters start once the fast oscillator runs; any drop restarts them
  for (genvar g = 0; g < 2; g++)
  begin : g_pers
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        pcnt_q[g] <= 11'h000;
      end
      else if (!sup_ok[g] || !osc48_en_out)
      begin
        pcnt_q[g] <= 11'h000;
      end
      else if (pcnt_q[g] != PERSIST_CYC)
      begin
        pcnt_q[g] <= pcnt_q[g] + 11'h001;
      end
    end
    assign pers_full[g] = (pcnt_q[g] == PERSIST_CYC);
  end

  // ----------------------------------------------------------------
  // Header check and address sums
  // ----------------------------------------------------------------
  function automatic logic region_ok(input logic [31:0] ptr, input logic [31:0] off);
    logic [32:0] end_a;
    end_a = {1'b0, ptr} + {1'b0, off} + IMG_SPAN;
    region_ok = (ptr != 32'h0000_0000) && (ptr != 32'hFFFF_FFFF) && (off != 32'h0000_0000)
             && (off != 32'hFFFF_FFFF) && (ptr < FLASH_BYTES) && (off < FLASH_BYTES)
             && (end_a <= {1'b0, FLASH_BYTES});
  endfunction

  assign hdr_ok   = region_ok(hdr_q[63:32], hdr_q[31:0]);
  assign img_addr = 24'(hdr_q[63:32] + hdr_q[31:0]);
  assign addr_a_c = otp_addr_valid_in ? otp_addr_in : {ADDR_BASE, pin_q.strap};

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  assign xfer_st   = (state_q == S_XCMD) || (state_q == S_XDATA);
  assign xfer_last = hdr_mode_q ? (idx_q == HDR_LAST) : (idx_q == IMG_LAST);

  // Rail loss sends everything back to hold from any state
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= S_HOLD;
    end
    else if (!pin_q.rail_ok)
    begin
      state_q <= S_HOLD;
    end
    else
    begin
      unique case (state_q)
        S_HOLD:    state_q <= S_REGS;
        S_REGS:    state_q <= S_TRIM;
        S_TRIM:    if (wait_q == TRIM_CYC - 12'h001) state_q <= S_ADDR;
        S_ADDR:    state_q <= S_DBAT;
        S_DBAT:    state_q <= S_PERSIST;
        S_PERSIST: if (pers_full[deadbat_q]) state_q <= S_ENABLE;
        S_ENABLE:  state_q <= S_XCMD;
        S_XCMD:    if (done_q && idx_q == CMD_LAST) state_q <= S_XDATA;
        S_XDATA:   if (done_q && xfer_last) state_q <= hdr_mode_q ? S_HCHK : S_ICHK;
        S_HCHK:    state_q <= (hdr_ok || !high_q) ? S_XCMD : S_INVALID;
        S_ICHK:    state_q <= (sum_q == 8'h00) ? S_DONE : (high_q ? S_INVALID : S_XCMD);
        S_DONE:    state_q <= S_DONE;
        S_INVALID: state_q <= S_INVALID;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Initialisation outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      core_rst_n_out        <= 1'b0;
      wait_q                <= 12'h000;
      trim_load_out         <= 1'b0;
      bus_addr_a_out        <= 7'h00;
      bus_addr_b_out        <= 7'h00;
      host_if_en_out        <= 1'b0;
      deadbat_q             <= 1'b0;
      adapter_switch_en_out <= 1'b0;
      osc48_en_out          <= 1'b0;
      periph_en_out         <= '0;
      boot_status_out       <= BFL_BOOT_NONE;
      cfg_valid_out         <= 1'b0;
      swd_route_out         <= 1'b0;
    end
    else if (!pin_q.rail_ok || state_q == S_REGS)
    begin
      core_rst_n_out        <= pin_q.rail_ok;
      wait_q                <= 12'h000;
      trim_load_out         <= pin_q.rail_ok;
      bus_addr_a_out        <= 7'h00;
      bus_addr_b_out        <= 7'h00;
      host_if_en_out        <= 1'b0;
      deadbat_q             <= 1'b0;
      adapter_switch_en_out <= 1'b0;
      osc48_en_out          <= 1'b0;
      periph_en_out         <= '0;
      boot_status_out       <= BFL_BOOT_NONE;
      cfg_valid_out         <= 1'b0;
      swd_route_out         <= 1'b0;
    end
    else
    begin
      core_rst_n_out <= 1'b1;
      trim_load_out  <= 1'b0;
      wait_q         <= (state_q == S_TRIM) ? wait_q + 12'h001 : 12'h000;
      unique case (state_q)
        S_ADDR:
        begin
          // Pin states latched once; later pin moves do not re-address
          bus_addr_a_out <= addr_a_c;
          bus_addr_b_out <= addr_a_c ^ {5'h00, pin_q.debug_ctl};
        end
        S_DBAT:
        begin
          host_if_en_out        <= 1'b1;
          osc48_en_out          <= 1'b1;
          deadbat_q             <= !pin_q.main_ok && pin_q.adp_ok;
          adapter_switch_en_out <= !pin_q.main_ok && pin_q.adp_ok && pin_q.adp_sel;
        end
        S_ENABLE: periph_en_out <= '1;
        S_DONE:
        begin
          boot_status_out <= high_q ? BFL_BOOT_HIGH : BFL_BOOT_LOW;
          cfg_valid_out   <= 1'b1;
        end
        S_INVALID:
        begin
          boot_status_out <= BFL_BOOT_INVALID;
          swd_route_out   <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Low power moves the core to the slow clock and stops the PHY clock
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      lp_q <= 1'b0;
    end
    else
    begin
      lp_q <= low_power_req_in && osc48_en_out;
    end
  end
  assign core_slow_clk_out  = lp_q || !osc48_en_out;
  assign usb_phy_clk_en_out = osc48_en_out && !lp_q;

  // ----------------------------------------------------------------
  // Transfer bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      idx_q <= 5'h00; addr_q <= LOW_HDR_ADDR; hdr_q <= '0;
      sum_q <= 8'h00; hdr_mode_q <= 1'b1; high_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        S_ENABLE:
        begin
          addr_q <= LOW_HDR_ADDR;
          hdr_mode_q <= 1'b1;
          high_q <= 1'b0;
          idx_q <= 5'h00;
        end
        S_XCMD: if (done_q) idx_q <= (idx_q == CMD_LAST) ? 5'h00 : idx_q + 5'h01;
        S_XDATA:
        begin
          if (done_q)
          begin
            idx_q <= idx_q + 5'h01;
            if (hdr_mode_q) hdr_q <= {hdr_q[55:0], rx_q};
            else sum_q <= sum_q + rx_q;
          end
        end
        S_HCHK:
        begin
          idx_q <= 5'h00;
          sum_q <= 8'h00;
          hdr_mode_q <= !hdr_ok;
          if (hdr_ok) addr_q <= img_addr;
          else
          begin
            high_q <= 1'b1;
            addr_q <= HIGH_HDR_ADDR;
          end
        end
        S_ICHK:
        begin
          idx_q <= 5'h00;
          if (sum_q != 8'h00)
          begin
            // Bad low image: fall back to the untouched high copy
            high_q <= 1'b1;
            hdr_mode_q <= 1'b1;
            addr_q <= HIGH_HDR_ADDR;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial flash engine
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (idx_q[1:0])
      2'h0:    spi_tx = FLASH_RD_CMD;
      2'h1:    spi_tx = addr_q[23:16];
      2'h2:    spi_tx = addr_q[15:8];
      default: spi_tx = addr_q[7:0];
    endcase
    if (state_q != S_XCMD) spi_tx = 8'h00;
  end
  assign spi_go = xfer_st && !busy_q && !done_q && !cs_n_q;

  // Select follows the sequencer; it rises on the edge of the last byte
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cs_n_q <= 1'b1;
    end
    else
    begin
      cs_n_q <= !(pin_q.rail_ok && xfer_st && !(state_q == S_XDATA && done_q && xfer_last));
    end
  end

  // Shift on falling edge, sample late in the high phase past synchroniser lag
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_q <= 1'b0; done_q <= 1'b0; sclk_q <= 1'b0; div_q <= 3'h0;
      bit_q <= 3'h0; sh_q <= 8'h00; rx_q <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      if (!pin_q.rail_ok)
      begin
        busy_q <= 1'b0;
        sclk_q <= 1'b0;
      end
      else if (!busy_q)
      begin
        sh_q <= spi_tx;
        if (spi_go)
        begin
          busy_q <= 1'b1;
          div_q  <= 3'h0;
          bit_q  <= 3'h0;
        end
      end
      else if (div_q == SPI_HALF_LAST)
      begin
        div_q  <= 3'h0;
        sclk_q <= !sclk_q;
        if (sclk_q)
        begin
          rx_q  <= {rx_q[6:0], pin_q.miso};
          sh_q  <= {sh_q[6:0], 1'b0};
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
      else
      begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  assign flash_sclk_out     = sclk_q;
  assign flash_mosi_out     = sh_q[7];
  assign flash_select_n_out = cs_n_q;

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  bfl_cfg_mem u_cfg (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .we_in      (state_q == S_XDATA && done_q && !hdr_mode_q && idx_q < IMG_LAST),
    .waddr_in   (idx_q[CFG_AW-1:0]),
    .wdata_in   (rx_q),
    .raddr_in   (cfg_rd_addr_in),
    .rdata_out  (cfg_rd_data_out)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  rail_hold_a: assert property (!pin_q.rail_ok |=> state_q == S_HOLD && !core_rst_n_out)
    else $error("rail loss did not hold boot");
  trim_order_a: assert property ($rose(state_q == S_ADDR) |-> $past(wait_q) == TRIM_CYC - 12'h001)
    else $error("addresses set before trims settled");
  trim_pulse_a: assert property (trim_load_out |-> state_q == S_TRIM ##1 !trim_load_out)
    else $error("trim load not a single pulse entering settle");
  host_after_addr_a: assert property ($rose(host_if_en_out) |-> $past(state_q, 2) == S_ADDR
                                      && $stable(bus_addr_a_out) && $stable(bus_addr_b_out))
    else $error("host interface enabled before addresses");
  dead_batt_a: assert property (state_q == S_DBAT && pin_q.rail_ok |=> adapter_switch_en_out == ($past(!pin_q.main_ok && pin_q.adp_ok && pin_q.adp_sel)))
    else $error("adapter switch decision wrong");
  persist_gate_a: assert property ($rose(periph_en_out != '0) |-> $past(pers_full[deadbat_q], 2))
    else $error("peripherals enabled before supply stable");
  sclk_idle_a: assert property (cs_n_q |-> !flash_sclk_out)
    else $error("flash clock active while deselected");
  sclk_half_a: assert property ($rose(flash_sclk_out) && pin_q.rail_ok |-> flash_sclk_out[*5] ##1 !flash_sclk_out)
    else $error("flash clock high phase wrong");
  swd_route_a: assert property (swd_route_out |-> boot_status_out == BFL_BOOT_INVALID && high_q)
    else $error("debug routed without both regions failing");
  img_addr_a: assert property (state_q == S_HCHK && hdr_ok && pin_q.rail_ok |=> addr_q == $past(img_addr))
    else $error("image address not pointer plus offset");
  low_first_a: assert property (state_q == S_ENABLE && pin_q.rail_ok |=> addr_q == LOW_HDR_ADDR && !high_q)
    else $error("low region not tried first");

  boot_low_c:  cover property (boot_status_out == BFL_BOOT_LOW);
  boot_high_c: cover property (boot_status_out == BFL_BOOT_HIGH);
  boot_inv_c:  cover property (swd_route_out);
  dead_batt_c: cover property (adapter_switch_en_out);

endmodule

// [include/bfl_pkg.sv]
/*
  Shared constants, carriers and state codes of the boot flash loader.
  Assumes a 100 MHz system clock and a read-only serial flash answering
  the plain read command in SPI mode 0.
*/
package bfl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CLK_HZ         = 1000000000 / CLK_PERIOD_NS;
  localparam int SPI_MAX_HZ     = 12000000;
  // Half period rounded up so the flash never sees more than 12 MHz
  localparam int SPI_HALF_CYC   = (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
  localparam logic [2:0] SPI_HALF_LAST = 3'(SPI_HALF_CYC - 1);
  localparam int TRIM_SETTLE_NS = 1000;
  localparam logic [11:0] TRIM_CYC = 12'((TRIM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PERSIST_NS     = 20000;
  localparam logic [10:0] PERSIST_CYC = 11'((PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Flash layout
  // ----------------------------------------------------------------
  localparam logic [23:0] LOW_HDR_ADDR  = 24'h000000;
  localparam logic [23:0] HIGH_HDR_ADDR = 24'h001000;
  localparam int          HDR_BLOCK_BYTES = 4096;
  localparam logic [31:0] FLASH_BYTES   = 32'h0010_0000;
  localparam logic [7:0]  FLASH_RD_CMD  = 8'h03;
  localparam logic [4:0]  CMD_LAST      = 5'h03;
  localparam logic [4:0]  HDR_LAST      = 5'h07;
  localparam int          CFG_BYTES     = 16;
  localparam int          CFG_AW        = 4;
  localparam logic [4:0]  IMG_LAST      = 5'h10;
  localparam logic [32:0] IMG_SPAN      = 33'h0_0000_0011;

  // ----------------------------------------------------------------
  // Bus address build
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_BASE = 4'h2;

  // ----------------------------------------------------------------
  // Carriers and codes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rail_ok;
    logic       main_ok;
    logic       adp_ok;
    logic       adp_sel;
    logic [1:0] debug_ctl;
    logic [2:0] strap;
    logic       miso;
  } bfl_pins_s;

  typedef struct packed {
    logic thermal_mon;
    logic thermal_sd;
    logic converter;
    logic checksum;
    logic gpio;
    logic vectored_irq;
  } bfl_periph_s;

  typedef enum logic [1:0] {
    BFL_BOOT_NONE,
    BFL_BOOT_LOW,
    BFL_BOOT_HIGH,
    BFL_BOOT_INVALID
  } bfl_boot_e;

  typedef enum logic [3:0] {
    S_HOLD, S_REGS, S_TRIM, S_ADDR, S_DBAT, S_PERSIST, S_ENABLE,
    S_XCMD, S_XDATA, S_HCHK, S_ICHK, S_DONE, S_INVALID
  } bfl_state_e;

endpackage

// [src/bfl_cfg_mem.sv]
/*
  Small store for the configuration bytes of the booted image.
  Assumes one writer on the system clock; read data is registered.
*/
`timescale 1ns/1ps
module bfl_cfg_mem
  import bfl_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              we_in,
  input  wire logic [CFG_AW-1:0] waddr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic [CFG_AW-1:0] raddr_in,
  output logic      [7:0]        rdata_out
);

  logic [7:0] mem_q [CFG_BYTES];

  // Array has no reset; contents are meaningful only once loaded
  always_ff @(posedge clk_sys_in)
  begin
    if (we_in)
    begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out <= 8'h00;
    end
    else
    begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule

// [tb/bfl_flash_model.sv]
/* Behavioural serial flash for the loader bench.
   Assumes mode 0 reads with command 03 and a pulled-up data line. */
`timescale 1ns/1ps
module bfl_flash_model (
  input  wire logic sclk_in,
  input  wire logic mosi_in,
  input  wire logic select_n_in,
  output logic      miso_out
);
  // ------------------------------------------------------------
  // Storage and shifter
  // ------------------------------------------------------------
  logic [7:0]  mem [logic [23:0]]; // Missing bytes read as erased
  logic [31:0] cmd_q;
  int          nbit;
  int          k;
  // Fresh count per frame, nothing carried over
  always @(negedge select_n_in) nbit = 0;
  // Command and address taken on rising edges, msb first
  always @(posedge sclk_in)
    if (!select_n_in)
    begin
      if (nbit < 32) cmd_q = {cmd_q[30:0], mosi_in};
      nbit = nbit + 1;
    end
  // Data launched on falling edges; pull-up level once released
  always @(negedge sclk_in or posedge select_n_in)
    if (select_n_in || nbit < 32 || cmd_q[31:24] != 8'h03)
      miso_out <= 1'b1;
    else
    begin
      k = nbit - 32;
      miso_out <= mem.exists(cmd_q[23:0] + 24'(k / 8)) ? mem[cmd_q[23:0] + 24'(k / 8)][7 - k % 8] : 1'b1;
    end
  initial miso_out = 1'b1;
endmodule

// [tb/boot_flash_image_loader_tb.sv]
/* Self-checking bench for the boot flash loader.
   Assumes the flash model beside it and a 100 MHz system clock. */
`timescale 1ns/1ps
module boot_flash_image_loader_tb import bfl_pkg::*;;
  logic              clk_sys_in, rst_n_in, internal_regulator_rail_ok_in, main_supply_input_ok_in;
  logic              adapter_supply_input_ok_in, adapter_power_select_pin_in, otp_addr_valid_in;
  logic              low_power_req_in, flash_miso_in, flash_sclk_out, flash_mosi_out, flash_select_n_out;
  logic              core_rst_n_out, trim_load_out, osc48_en_out, core_slow_clk_out, usb_phy_clk_en_out;
  logic              adapter_switch_en_out, host_if_en_out, swd_route_out, cfg_valid_out;
  logic [1:0]        debug_control_pins_in;
  logic [2:0]        addr_strap_in;
  logic [6:0]        otp_addr_in, bus_addr_a_out, bus_addr_b_out;
  logic [CFG_AW-1:0] cfg_rd_addr_in;
  logic [7:0]        cfg_rd_data_out;
  bfl_periph_s       periph_en_out;
  bfl_boot_e         boot_status_out;
  int                n_mismatch = 0;
  int                num_checks = 0;
  logic [7:0]        exp_cfg [CFG_BYTES];

  bfl_loader u_bfl_loader (.*);
  bfl_flash_model u_bfl_flash_model (.sclk_in(flash_sclk_out), .mosi_in(flash_mosi_out),
    .select_n_in(flash_select_n_out), .miso_out(flash_miso_in));

  // ------------------------------------------------------------
  // Clock and helpers
  // ------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Inputs move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  // Big-endian pointer then offset
  task automatic put_hdr(input logic [23:0] base, input logic [31:0] ptr, input logic [31:0] off);
    for (int i = 0; i < 4; i++)
    begin
      u_bfl_flash_model.mem[base + 24'(i)] = ptr[31 - 8 * i -: 8];
      u_bfl_flash_model.mem[base + 24'(i + 4)] = off[31 - 8 * i -: 8];
    end
  endtask
  // Settings then a zero-sum byte, spoilt on request
  task automatic put_img(input logic [23:0] a, input logic [7:0] seed, input logic bad);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < CFG_BYTES; i++)
    begin
      exp_cfg[i] = seed ^ 8'(i * 37);
      u_bfl_flash_model.mem[a + 24'(i)] = exp_cfg[i];
      sum = sum + exp_cfg[i];
    end
    u_bfl_flash_model.mem[a + 24'(CFG_BYTES)] = 8'h00 - sum + {7'h00, bad};
  endtask
  // Reset, hold rail low a while, then boot to a verdict
  task automatic boot(input logic main_ok, input logic adp_ok);
    logic seen;
    seen = 1'b0;
    rst_n_in = 1'b0;
    internal_regulator_rail_ok_in = 1'b0;
    main_supply_input_ok_in = main_ok;
    adapter_supply_input_ok_in = adp_ok;
    cyc(16);
    rst_n_in = 1'b1;
    cyc(40);
    chk(core_rst_n_out === 1'b0 && host_if_en_out === 1'b0, "core left reset");
    internal_regulator_rail_ok_in = 1'b1;
    for (int i = 0; i < 20000 && boot_status_out === BFL_BOOT_NONE; i++)
    begin
      seen = seen | (trim_load_out === 1'b1);
      cyc(1);
    end
    chk(seen, "trim load pulse missing");
    cyc(2);
    chk(core_rst_n_out === 1'b1 && periph_en_out === 6'h3F && osc48_en_out === 1'b1, "init");
  endtask
  task automatic rd_cfg();
    for (int i = 0; i < CFG_BYTES; i++)
    begin
      cfg_rd_addr_in = 4'(i);
      cyc(2);
      chk(cfg_valid_out === 1'b1 && cfg_rd_data_out === exp_cfg[i], "config byte");
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_low();
    put_hdr(LOW_HDR_ADDR, 32'h0000_2000, 32'h0000_0100);
    put_img(24'h002100, 8'hA5, 1'b0);
    boot(1'b1, 1'b0);
    chk(boot_status_out === BFL_BOOT_LOW && swd_route_out === 1'b0, "low region");
    chk(bus_addr_a_out === {ADDR_BASE, 3'h5} && bus_addr_b_out === {ADDR_BASE, 3'h7}
        && host_if_en_out === 1'b1, "addr");
    chk(adapter_switch_en_out === 1'b0 && usb_phy_clk_en_out === 1'b1, "switch or phy");
    rd_cfg();
    low_power_req_in = 1'b1;
    cyc(4);
    chk(core_slow_clk_out === 1'b1 && usb_phy_clk_en_out === 1'b0, "low power clocks");
    low_power_req_in = 1'b0;
  endtask
  // Spoilt low image, dead battery supply
  task automatic t_high();
    u_bfl_flash_model.mem.delete();
    put_hdr(LOW_HDR_ADDR, 32'h0000_2000, 32'h0000_0100);
    put_img(24'h002100, 8'h3C, 1'b1);
    put_hdr(HIGH_HDR_ADDR, 32'h0000_8000, 32'h0000_0040);
    put_img(24'h008040, 8'h5A, 1'b0);
    boot(1'b0, 1'b1);
    chk(boot_status_out === BFL_BOOT_HIGH && adapter_switch_en_out === 1'b1, "high region");
    rd_cfg();
  endtask
  // Both headers invalid, address from one-time memory
  task automatic t_bad();
    u_bfl_flash_model.mem.delete();
    put_hdr(LOW_HDR_ADDR, 32'hFFFF_FFFF, 32'h0000_0100);
    put_hdr(HIGH_HDR_ADDR, 32'h0010_0000, 32'h0000_0040);
    otp_addr_valid_in = 1'b1;
    boot(1'b1, 1'b0);
    chk(boot_status_out === BFL_BOOT_INVALID && swd_route_out === 1'b1, "invalid flow");
    chk(bus_addr_a_out === 7'h55 && bus_addr_b_out === 7'h57, "otp addr");
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    {rst_n_in, internal_regulator_rail_ok_in, otp_addr_valid_in, low_power_req_in} = 4'h0;
    {main_supply_input_ok_in, adapter_supply_input_ok_in, adapter_power_select_pin_in} = 3'h7;
    debug_control_pins_in = 2'h2;
    addr_strap_in = 3'h5;
    otp_addr_in = 7'h55;
    cfg_rd_addr_in = 4'h0;
    t_low();
    t_high();
    t_bad();
    report_and_stop();
  end
  // Three boots take about 17k cycles; give up at 50k
  initial
  begin
    #500us;
    n_mismatch++;
    report_and_stop();
  end
endmodule
